// >>> inc/srsc_pkg.sv
// constants and types of the system reset state controller
package srsc_pkg;
   // widths
   localparam int ADDR_W = 8;
   localparam int PORT_W = 16;
   localparam int AHB_W = 8;
   localparam int APB_W = 16;
   localparam int IRQ_W = 8;
   localparam int TMR_W = 4;
   localparam int CAUSE_W = 5;
   localparam int CNT_W = 3;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_AHB = 8'h04;
   localparam logic [7:0] OFS_APB = 8'h08;
   localparam logic [7:0] OFS_PLAT = 8'h0c;
   localparam logic [7:0] OFS_PMODE = 8'h10;
   localparam logic [7:0] OFS_PULL = 8'h14;
   localparam logic [7:0] OFS_WDT = 8'h18;
   localparam logic [7:0] OFS_CLK = 8'h1c;
   localparam logic [7:0] OFS_IRQ = 8'h20;
   localparam logic [7:0] OFS_CAUSE = 8'h24;
   // field positions
   localparam int CTRL_SWRST_BIT = 0;
   localparam int CTRL_BUSY_BIT = 8;
   localparam int AHB_USB_BIT = 7;
   localparam int APB_WDT_BIT = 0;
   localparam int APB_EMIF_BIT = 1;
   localparam int APB_DMAX_BIT = 2;
   localparam int WDT_EN_BIT = 0;
   localparam int WDT_SRC_BIT = 1;
   localparam int TMR_LSB = 8;
   localparam int CAUSE_POR = 0;
   localparam int CAUSE_VDD = 1;
   localparam int CAUSE_PIN = 2;
   localparam int CAUSE_WDT = 3;
   localparam int CAUSE_SW = 4;
   // values after reset
   localparam logic [AHB_W-1:0] AHB_RST = 8'h7f;
   localparam logic [APB_W-1:0] APB_RST = 16'h0007;
   localparam logic [PORT_W-1:0] PLAT_RST = 16'hffff;
   localparam logic [PORT_W-1:0] PMODE_RST = 16'hffff;
   localparam logic [PORT_W-1:0] PULL_RST = 16'hffff;
   localparam logic [IRQ_W-1:0] IRQ_RST = 8'h00;
   localparam logic [TMR_W-1:0] TMR_RST = 4'h0;
   localparam logic [CAUSE_W-1:0] CAUSE_RST = 5'h01;
   localparam logic [31:0] BOOT_ADDR = 32'h00000000;
   // bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // timing
   localparam int CLK_NS = 100;
   localparam int RELEASE_NS = 400;
   localparam int GUARD_NS = 300;
   localparam logic [CNT_W-1:0] RELEASE_CYC = CNT_W'((RELEASE_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [CNT_W-1:0] GUARD_CYC = CNT_W'((GUARD_NS + CLK_NS - 1) / CLK_NS);
   // modes and states
   typedef enum logic [1:0] {CLK_INT_OSC, CLK_EXT_OSC, CLK_PLL, CLK_LP_OSC} srsc_clk_t;
   typedef enum logic {WDT_LFO, WDT_SYSCLK} srsc_wdt_src_t;
   typedef enum logic [1:0] {ST_HELD, ST_EXIT, ST_RUN} srsc_state_t;
endpackage : srsc_pkg

// >>> inc/srsc_regbus_if.sv
// register access strobes between the bus slave and the register file
interface srsc_regbus_if;
   logic wr_en;
   logic [7:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic wr_err;
   logic [7:0] rd_addr;
   logic [31:0] rd_data;
   logic rd_err;
   modport slave (output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                  input wr_err, rd_data, rd_err);
   modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                 output wr_err, rd_data, rd_err);
endinterface : srsc_regbus_if

// >>> test/srsc_partner.sv
// far-side model: reset pad with pull-up and a core logging its first fetch
module srsc_partner (
   // clock
   input wire logic aclk,
   // controller side
   input wire logic reset_pin_oe_n,
   input wire logic core_start,
   input wire logic [31:0] fetch_addr,
   // pad side
   input wire logic ext_low,
   output logic reset_pin_i,
   output logic [31:0] first_fetch
);
   timeunit 1ns;
   timeprecision 1ns;
   // open drain: low when either party pulls, pull-up otherwise
   assign reset_pin_i = !(ext_low || !reset_pin_oe_n);
   // core takes its start address on the start pulse
   always @(posedge aclk) if (core_start) first_fetch <= fetch_addr;
endmodule : srsc_partner

// >>> test/system_reset_state_control_bench.sv
// self-checking bench for the reset state controller
module system_reset_state_control_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic por_req = 0, vdd_mon_req = 0, wdt_expired = 0, ext_low = 0, awready, wready, bvalid;
   logic arready, rvalid, reset_pin_i, reset_pin_o, reset_pin_oe_n, core_halt, pc_clear;
   logic core_start, module_init, ram_write_block, wdt_enable;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, ahb_clk_en, irq_enable;
   logic [31:0] wdata = 32'h0, rdata, fetch_addr, first_fetch, d;
   logic [15:0] apb_clk_en, port_latch, port_open_drain, port_pullup_en;
   logic [3:0] wstrb = 4'hf, timer_enable;
   logic [1:0] bresp, rresp, r;
   srsc_pkg::srsc_clk_t sys_clk_sel;
   srsc_pkg::srsc_wdt_src_t wdt_clk_sel;
   int errors = 0, cmp_count = 0;
   // expected defaults of offsets 0x04 to 0x20
   int exp_q[$] = '{'h7f, 'h7, 'hffff, 'hffff, 'hffff, 'h1, 0, 0};
   // writable bits of the same registers
   int msk_q[$] = '{'hff, 'hffff, 'hffff, 'hffff, 'hffff, 'h3, 'h3, 'hfff};
   always #50 aclk = ~aclk;
   srsc_top i_srsc_top (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready, .por_req, .vdd_mon_req, .wdt_expired, .reset_pin_i, .reset_pin_o,
      .reset_pin_oe_n, .core_halt, .pc_clear, .core_start, .fetch_addr, .module_init,
      .ram_write_block, .ahb_clk_en, .apb_clk_en, .sys_clk_sel, .wdt_enable, .wdt_clk_sel,
      .port_latch, .port_open_drain, .port_pullup_en, .irq_enable, .timer_enable);
   srsc_partner i_srsc_partner (.aclk, .reset_pin_oe_n, .core_start, .fetch_addr, .ext_low,
      .reset_pin_i, .first_fetch);
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // each half is released at the rising edge that takes it
   task automatic wr(logic [7:0] a, logic [31:0] v);
      awaddr <= a;
      wdata <= v;
      {awvalid, wvalid, bready} <= 3'b111;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while ((awvalid && !awready) || (wvalid && !wready));
      do @(posedge aclk); while (!bvalid);
      bready <= 1'b0;
   endtask : wr
   // rready stays up between reads, data taken at the handshake edge
   task automatic rd(logic [7:0] a, output logic [31:0] v, output logic [1:0] e);
      araddr <= a;
      {arvalid, rready} <= 2'b11;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
      v = rdata;
      e = rresp;
   endtask : rd
   task automatic to_run;
      do @(negedge aclk); while (core_halt);
      @(posedge aclk);
   endtask : to_run
   task automatic defaults(int cause);
      foreach (exp_q[i]) begin
         rd(8'(4 * i + 4), d, r);
         check("reg", d, exp_q[i]);
      end
      rd(8'h24, d, r);
      check("cause", d, cause);
      check("fetch", first_fetch, 0);
      check("gates", {ahb_clk_en, apb_clk_en}, 24'h7f0007);
      check("ports", {&port_latch, &port_open_drain, &port_pullup_en}, 3'h7);
      check("outs", {pc_clear, module_init, reset_pin_o, bresp, ram_write_block, wdt_enable,
         wdt_clk_sel, sys_clk_sel, irq_enable, timer_enable}, 32'h00008000);
   endtask : defaults
   task automatic tally_and_finish;
      $display("errors %0d comparisons %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : tally_and_finish
   // main sequence: power-on, then one reset of each source kind
   initial begin
      int bitq[4] = '{3, 1, 0, 2};
      int cause = 1;
      int ix;
      logic [31:0] wv;
      void'($urandom(30732));
      @(negedge aclk);
      check("held", {core_halt, ram_write_block, reset_pin_oe_n}, 3'b110);
      @(posedge aclk);
      aresetn <= 1'b1;
      to_run;
      defaults(cause);
      for (int k = 0; k < 4; k++) begin
         ix = $urandom % 8;
         wv = $urandom;
         wr(8'(4 * ix + 4), wv);
         rd(8'(4 * ix + 4), d, r);
         check("written", d, wv & msk_q[ix]);
         {ext_low, por_req, vdd_mon_req, wdt_expired} <= 4'(1 << k);
         repeat (7) @(negedge aclk);
         check("pin", {core_halt, reset_pin_oe_n}, {1'b1, k == 0 || k == 3});
         @(posedge aclk);
         {ext_low, por_req, vdd_mon_req, wdt_expired} <= 4'h0;
         to_run;
         cause = k == 2 ? 1 : cause | (1 << bitq[k]);
         defaults(cause);
      end
      // software reset through the control register
      wr(8'h00, 32'h00000001);
      repeat (3) @(negedge aclk);
      check("swrst", core_halt, 1'b1);
      to_run;
      defaults(cause | 16);
      rd(8'h40, d, r);
      check("unmapped", r, 2'h2);
      tally_and_finish;
   end
   // hang guard, far beyond the expected run
   initial begin
      #2000000;
      errors++;
      tally_and_finish;
   end
endmodule : system_reset_state_control_bench

// >>> verilog/srsc_axil_slave.sv
// axi4-lite slave turning bus transfers into register strobes
module srsc_axil_slave (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // write channels
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // read channels
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // register side
   srsc_regbus_if.slave rb
);
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic [7:0] araddr_q;
   logic rd_pend;

   // write fires once both halves are held and no answer is pending
   assign rb.wr_en = !awready && !wready && !bvalid;
   assign rb.wr_addr = awaddr_q;
   assign rb.wr_data = wdata_q;
   assign rb.wr_strb = wstrb_q;
   assign rb.rd_addr = araddr_q;

   // write address and data in either order, response after both
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'h1;
         wready <= 1'h1;
         bvalid <= 1'h0;
         bresp <= srsc_pkg::RESP_OKAY;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
      end else begin
         if (awvalid && awready) begin
            awaddr_q <= awaddr;
            awready <= 1'h0;
         end
         if (wvalid && wready) begin
            wdata_q <= wdata;
            wstrb_q <= wstrb;
            wready <= 1'h0;
         end
         if (rb.wr_en) begin
            bvalid <= 1'h1;
            bresp <= rb.wr_err ? srsc_pkg::RESP_SLVERR : srsc_pkg::RESP_OKAY;
         end else if (bvalid && bready) begin
            bvalid <= 1'h0;
            awready <= 1'h1;
            wready <= 1'h1;
         end
      end
   end

   // read: address held one cycle, then data sampled from the register view
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'h1;
         rd_pend <= 1'h0;
         rvalid <= 1'h0;
         rdata <= 32'h00000000;
         rresp <= srsc_pkg::RESP_OKAY;
         araddr_q <= 8'h00;
      end else begin
         if (arvalid && arready) begin
            araddr_q <= araddr;
            arready <= 1'h0;
            rd_pend <= 1'h1;
         end else if (rd_pend) begin
            rd_pend <= 1'h0;
            rvalid <= 1'h1;
            rdata <= rb.rd_err ? 32'h00000000 : rb.rd_data;
            rresp <= rb.rd_err ? srsc_pkg::RESP_SLVERR : srsc_pkg::RESP_OKAY;
         end else if (rvalid && rready) begin
            rvalid <= 1'h0;
            arready <= 1'h1;
         end
      end
   end
endmodule : srsc_axil_slave

// >>> verilog/srsc_rst_sync.sv
// reset source merge, pin synchroniser and synchronous release
module srsc_rst_sync (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // sources
   input wire logic reset_pin_i,
   input wire logic pin_mask,
   input wire logic [3:0] src_req,
   // results
   output logic pin_req,
   output logic hold
);
   logic pin_s1;
   logic pin_s2;
   logic any_req;
   logic [srsc_pkg::CNT_W-1:0] cnt;

   // two-flop pin synchroniser, idle high
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_s1 <= 1'h1;
         pin_s2 <= 1'h1;
      end else begin
         pin_s1 <= reset_pin_i;
         pin_s2 <= pin_s1;
      end
   end

   // masked while we drive the pin ourselves, else it would hold itself in reset
   assign pin_req = !pin_s2 && !pin_mask;
   assign any_req = (|src_req) || pin_req;

   // hold while any source, then count out before release
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hold <= 1'h1;
         cnt <= srsc_pkg::RELEASE_CYC;
      end else if (any_req) begin
         hold <= 1'h1;
         cnt <= srsc_pkg::RELEASE_CYC;
      end else if (cnt != '0) begin
         cnt <= cnt - 1'b1;
      end else begin
         hold <= 1'h0;
      end
   end

   hold_on_req_a: assert property (@(posedge aclk) disable iff (!aresetn)
      any_req |=> hold) else $error("reset hold missed a source");
   release_sync_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (hold && !any_req && cnt == '0) |=> !hold) else $error("late release");
endmodule : srsc_rst_sync

// >>> verilog/srsc_top.sv
// reset state controller: sequencing, reset defaults and the register file
//
// Local design decisions: the address map and the AXI4-Lite register port.
module srsc_top (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write channels
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // axi4-lite read channels
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // reset sources
   input wire logic por_req,
   input wire logic vdd_mon_req,
   input wire logic wdt_expired,
   // external reset pin, open drain
   input wire logic reset_pin_i,
   output logic reset_pin_o,
   output logic reset_pin_oe_n,
   // processor core and memories
   output logic core_halt,
   output logic pc_clear,
   output logic core_start,
   output logic [31:0] fetch_addr,
   output logic module_init,
   output logic ram_write_block,
   // clock control
   output logic [srsc_pkg::AHB_W-1:0] ahb_clk_en,
   output logic [srsc_pkg::APB_W-1:0] apb_clk_en,
   output srsc_pkg::srsc_clk_t sys_clk_sel,
   output logic wdt_enable,
   output srsc_pkg::srsc_wdt_src_t wdt_clk_sel,
   // port pins
   output logic [srsc_pkg::PORT_W-1:0] port_latch,
   output logic [srsc_pkg::PORT_W-1:0] port_open_drain,
   output logic [srsc_pkg::PORT_W-1:0] port_pullup_en,
   // interrupts and timers
   output logic [srsc_pkg::IRQ_W-1:0] irq_enable,
   output logic [srsc_pkg::TMR_W-1:0] timer_enable
);
   srsc_pkg::srsc_state_t state;
   srsc_pkg::srsc_state_t next_state;
   logic hold;
   logic pin_req;
   logic pin_mask;
   logic sw_req;
   logic drv_cause;
   logic [srsc_pkg::CNT_W-1:0] pin_guard;
   logic [srsc_pkg::CAUSE_W-1:0] cause;
   logic [srsc_pkg::CAUSE_W-1:0] cause_set;
   logic [srsc_pkg::CAUSE_W-1:0] cause_clr;
   logic [31:0] rd_word;
   logic [31:0] wword;
   logic wr_ok;
   logic in_defaults;

   srsc_regbus_if rb ();

   // bus slave
   srsc_axil_slave u_bus (
      .aclk(aclk),
      .aresetn(aresetn),
      .awaddr(awaddr),
      .awvalid(awvalid),
      .awready(awready),
      .wdata(wdata),
      .wstrb(wstrb),
      .wvalid(wvalid),
      .wready(wready),
      .bresp(bresp),
      .bvalid(bvalid),
      .bready(bready),
      .araddr(araddr),
      .arvalid(arvalid),
      .arready(arready),
      .rdata(rdata),
      .rresp(rresp),
      .rvalid(rvalid),
      .rready(rready),
      .rb(rb.slave)
   );

   // pin source ignored while we pull it and until the pad settles
   assign pin_mask = !reset_pin_oe_n || (pin_guard != '0);

   // source merge and synchronous release
   srsc_rst_sync u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .reset_pin_i(reset_pin_i),
      .pin_mask(pin_mask),
      .src_req({sw_req, wdt_expired, vdd_mon_req, por_req}),
      .pin_req(pin_req),
      .hold(hold)
   );

   // byte-lane merge of a write into the current word
   function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] din,
                                              input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = din[i*8 +: 8];
         end
      end
      return res;
   endfunction : lane_merge

   // decode shared by the read and write error answers
   function automatic logic is_mapped(input logic [7:0] a);
      return (a == srsc_pkg::OFS_CTRL) || (a == srsc_pkg::OFS_AHB) ||
             (a == srsc_pkg::OFS_APB) || (a == srsc_pkg::OFS_PLAT) ||
             (a == srsc_pkg::OFS_PMODE) || (a == srsc_pkg::OFS_PULL) ||
             (a == srsc_pkg::OFS_WDT) || (a == srsc_pkg::OFS_CLK) ||
             (a == srsc_pkg::OFS_IRQ) || (a == srsc_pkg::OFS_CAUSE);
   endfunction : is_mapped

   // register view, bits above each field read zero
   function automatic logic [31:0] reg_view(input logic [7:0] a);
      logic [31:0] v;
      v = 32'h00000000;
      if (a == srsc_pkg::OFS_CTRL) begin
         v[srsc_pkg::CTRL_BUSY_BIT] = (state != srsc_pkg::ST_RUN);
      end else if (a == srsc_pkg::OFS_AHB) begin
         v[srsc_pkg::AHB_W-1:0] = ahb_clk_en;
      end else if (a == srsc_pkg::OFS_APB) begin
         v[srsc_pkg::APB_W-1:0] = apb_clk_en;
      end else if (a == srsc_pkg::OFS_PLAT) begin
         v[srsc_pkg::PORT_W-1:0] = port_latch;
      end else if (a == srsc_pkg::OFS_PMODE) begin
         v[srsc_pkg::PORT_W-1:0] = port_open_drain;
      end else if (a == srsc_pkg::OFS_PULL) begin
         v[srsc_pkg::PORT_W-1:0] = port_pullup_en;
      end else if (a == srsc_pkg::OFS_WDT) begin
         v[srsc_pkg::WDT_EN_BIT] = wdt_enable;
         v[srsc_pkg::WDT_SRC_BIT] = wdt_clk_sel;
      end else if (a == srsc_pkg::OFS_CLK) begin
         v[1:0] = sys_clk_sel;
      end else if (a == srsc_pkg::OFS_IRQ) begin
         v[srsc_pkg::IRQ_W-1:0] = irq_enable;
         v[srsc_pkg::TMR_LSB +: srsc_pkg::TMR_W] = timer_enable;
      end else if (a == srsc_pkg::OFS_CAUSE) begin
         v[srsc_pkg::CAUSE_W-1:0] = cause;
      end
      return v;
   endfunction : reg_view

   // read data and merged write word
   always_comb begin
      rd_word = reg_view(rb.rd_addr);
      wword = lane_merge(reg_view(rb.wr_addr), rb.wr_data, rb.wr_strb);
   end

   assign rb.rd_data = rd_word;
   assign rb.rd_err = !is_mapped(rb.rd_addr);
   assign rb.wr_err = !is_mapped(rb.wr_addr);
   // writes during reset are answered but dropped: defaults must win
   assign wr_ok = rb.wr_en && (state == srsc_pkg::ST_RUN);
   assign in_defaults = !aresetn || (state == srsc_pkg::ST_HELD);

   // reset sequence
   always_comb begin
      next_state = state;
      case (state)
         srsc_pkg::ST_HELD: begin
            if (!hold) begin
               next_state = srsc_pkg::ST_EXIT;
            end
         end
         srsc_pkg::ST_EXIT: begin
            next_state = hold ? srsc_pkg::ST_HELD : srsc_pkg::ST_RUN;
         end
         default: begin
            if (hold) begin
               next_state = srsc_pkg::ST_HELD;
            end
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= srsc_pkg::ST_HELD;
      end else begin
         state <= next_state;
      end
   end

   // core control, registered from the next state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         core_halt <= 1'h1;
         pc_clear <= 1'h1;
         core_start <= 1'h0;
         fetch_addr <= srsc_pkg::BOOT_ADDR;
         module_init <= 1'h1;
         ram_write_block <= 1'h1;
      end else begin
         core_halt <= (next_state != srsc_pkg::ST_RUN);
         pc_clear <= (next_state != srsc_pkg::ST_RUN);
         core_start <= (next_state == srsc_pkg::ST_EXIT);
         fetch_addr <= srsc_pkg::BOOT_ADDR;
         module_init <= (next_state == srsc_pkg::ST_HELD);
         // ram is never cleared, only shielded from stray writes
         ram_write_block <= (next_state != srsc_pkg::ST_RUN);
      end
   end

   // software reset request, one cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sw_req <= 1'h0;
      end else begin
         sw_req <= wr_ok && (rb.wr_addr == srsc_pkg::OFS_CTRL) &&
                   wword[srsc_pkg::CTRL_SWRST_BIT];
      end
   end

   // reset cause: a power-on reset clears all other bits, a written one clears any bit
   assign cause_set = {sw_req, wdt_expired, pin_req, vdd_mon_req, por_req};
   assign cause_clr = (wr_ok && rb.wr_addr == srsc_pkg::OFS_CAUSE && rb.wr_strb[0]) ?
                      rb.wr_data[srsc_pkg::CAUSE_W-1:0] : '0;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cause <= srsc_pkg::CAUSE_RST;
      end else if (por_req) begin
         cause <= cause_set;
      end else begin
         // a new event outranks a clear in the same cycle
         cause <= (cause & ~cause_clr) | cause_set;
      end
   end

   // pin drive for power-on and supply-monitor resets
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         drv_cause <= 1'h1;
      end else if (por_req || vdd_mon_req) begin
         drv_cause <= 1'h1;
      end else if (state == srsc_pkg::ST_EXIT) begin
         drv_cause <= 1'h0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         reset_pin_o <= 1'h0;
         reset_pin_oe_n <= 1'h0;
      end else begin
         reset_pin_o <= 1'h0;
         reset_pin_oe_n <= !((next_state != srsc_pkg::ST_RUN) && drv_cause);
      end
   end

   // guard: synchroniser still shows our own low for a few cycles
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_guard <= srsc_pkg::GUARD_CYC;
      end else if (!reset_pin_oe_n) begin
         pin_guard <= srsc_pkg::GUARD_CYC;
      end else if (pin_guard != '0) begin
         pin_guard <= pin_guard - 1'b1;
      end
   end

   // bus clock gates
   always_ff @(posedge aclk) begin
      if (in_defaults) begin
         ahb_clk_en <= srsc_pkg::AHB_RST;
         apb_clk_en <= srsc_pkg::APB_RST;
      end else if (wr_ok && rb.wr_addr == srsc_pkg::OFS_AHB) begin
         ahb_clk_en <= wword[srsc_pkg::AHB_W-1:0];
      end else if (wr_ok && rb.wr_addr == srsc_pkg::OFS_APB) begin
         apb_clk_en <= wword[srsc_pkg::APB_W-1:0];
      end
   end

   // port pin state
   always_ff @(posedge aclk) begin
      if (in_defaults) begin
         port_latch <= srsc_pkg::PLAT_RST;
         port_open_drain <= srsc_pkg::PMODE_RST;
         port_pullup_en <= srsc_pkg::PULL_RST;
      end else if (wr_ok && rb.wr_addr == srsc_pkg::OFS_PLAT) begin
         port_latch <= wword[srsc_pkg::PORT_W-1:0];
      end else if (wr_ok && rb.wr_addr == srsc_pkg::OFS_PMODE) begin
         port_open_drain <= wword[srsc_pkg::PORT_W-1:0];
      end else if (wr_ok && rb.wr_addr == srsc_pkg::OFS_PULL) begin
         port_pullup_en <= wword[srsc_pkg::PORT_W-1:0];
      end
   end

   // system clock and watchdog
   always_ff @(posedge aclk) begin
      if (in_defaults) begin
         sys_clk_sel <= srsc_pkg::CLK_INT_OSC;
         wdt_enable <= 1'h1;
         wdt_clk_sel <= srsc_pkg::WDT_LFO;
      end else if (wr_ok && rb.wr_addr == srsc_pkg::OFS_CLK) begin
         sys_clk_sel <= srsc_pkg::srsc_clk_t'(wword[1:0]);
      end else if (wr_ok && rb.wr_addr == srsc_pkg::OFS_WDT) begin
         wdt_enable <= wword[srsc_pkg::WDT_EN_BIT];
         wdt_clk_sel <= srsc_pkg::srsc_wdt_src_t'(wword[srsc_pkg::WDT_SRC_BIT]);
      end
   end

   // interrupt and timer enables
   always_ff @(posedge aclk) begin
      if (in_defaults) begin
         irq_enable <= srsc_pkg::IRQ_RST;
         timer_enable <= srsc_pkg::TMR_RST;
      end else if (wr_ok && rb.wr_addr == srsc_pkg::OFS_IRQ) begin
         irq_enable <= wword[srsc_pkg::IRQ_W-1:0];
         timer_enable <= wword[srsc_pkg::TMR_LSB +: srsc_pkg::TMR_W];
      end
   end

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   core_halted_a: assert property ((state != srsc_pkg::ST_RUN) |-> core_halt)
      else $error("core ran while in reset");
   irq_off_a: assert property ((state == srsc_pkg::ST_EXIT) |->
      (irq_enable == '0) && (timer_enable == '0))
      else $error("interrupts or timers live at exit");
   ahb_gates_a: assert property ((state == srsc_pkg::ST_EXIT) |->
      ahb_clk_en == srsc_pkg::AHB_RST && !ahb_clk_en[srsc_pkg::AHB_USB_BIT])
      else $error("fast-bus gates wrong at exit");
   apb_gates_a: assert property ((state == srsc_pkg::ST_EXIT) |->
      apb_clk_en == srsc_pkg::APB_RST)
      else $error("peripheral-bus gates wrong at exit");
   port_safe_a: assert property ((state == srsc_pkg::ST_EXIT) |->
      (&port_latch) && (&port_open_drain))
      else $error("ports not safe at exit");
   pullups_on_a: assert property ((state != srsc_pkg::ST_RUN) |=> (&port_pullup_en))
      else $error("pull-ups off during reset");
   pin_driven_a: assert property ((state == srsc_pkg::ST_HELD && drv_cause) |=>
      !reset_pin_oe_n && !reset_pin_o)
      else $error("reset pin not driven");
   pin_free_a: assert property ((state == srsc_pkg::ST_RUN) |-> reset_pin_oe_n)
      else $error("reset pin driven while running");
   boot_start_a: assert property ((core_start && !hold) |-> pc_clear && fetch_addr == 32'h00000000
      && sys_clk_sel == srsc_pkg::CLK_INT_OSC ##1 !core_halt)
      else $error("bad start after reset");
   wdt_start_a: assert property (core_start |-> wdt_enable &&
      wdt_clk_sel == srsc_pkg::WDT_LFO)
      else $error("watchdog not running from slow clock");
   cause_keep_a: assert property ((!por_req && !$past(por_req) && !cause_clr[srsc_pkg::CAUSE_POR]
      && cause[srsc_pkg::CAUSE_POR]) |=> cause[srsc_pkg::CAUSE_POR])
      else $error("power-on flag lost");

   por_exit_c: cover property (por_req ##[1:30] core_start);
   wdt_exit_c: cover property (wdt_expired ##[1:30] core_start);
   sw_exit_c: cover property (sw_req ##[1:30] core_start);
   bus_write_c: cover property (wr_ok ##1 bvalid);
endmodule : srsc_top
